/* rtl/sensor_serial_slave_port.sv */
// Two-wire and four-wire serial slave port with interrupt flag logic
//
// How it works
// - Registers reachable over two-wire at 400 kHz or four-wire at 8 MHz.
// - Two-wire address is 110100 plus the address select pin as lsb.
// - SDA fall with SCL high starts; SDA rise with SCL high stops.
// - Repeated start keeps the transaction and restarts address reception.
// - Bytes are eight bits plus a ninth acknowledge bit held low.
// - Device stretches SCL low until read data is ready.
// - First byte after start is address plus direction; device acknowledges.
// - Write: address with 0, index byte, data bytes, each acknowledged.
// - Further written bytes go to the next register index.
// - Read: write index, repeated start with direction 1, device sends data.
// - Master ack asks for another byte; nack then stop ends the read.
// - Four-wire select goes low for a transaction and high after it.
// - Serial data out is released while select is high.
// - Four-wire bytes shift msb first.
// - Sample on rising serial clock, change data on falling edge.
// - First four-wire byte is direction bit then 7-bit index; data follows.
// - Single and burst transfers within one select-low period.
// - Interrupt pin and status flags naming the source.
// - Each interrupt source has its own enable.
`timescale 1ns/1ps
module sensor_serial_slave_port
  import serial_port_pkg::*;
(
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic                 scl_in,
  output logic                      scl_out,
  output logic                      scl_oe_n,
  input  wire logic                 sda_in,
  output logic                      sda_out,
  output logic                      sda_oe_n,
  input  wire logic                 select_n,
  input  wire logic                 addr_lsb_select,
  output logic                      serial_data_out,
  output logic                      serial_data_out_oe_n,
  input  wire logic                 twowire_port_disable,
  output reg_write_type             reg_write,
  output logic [7:0]                read_index,
  input  wire logic [7:0]           read_data,
  input  wire logic                 read_ready,
  output logic                      bus_busy,
  input  wire logic [IRQ_COUNT-1:0] irq_event,
  input  wire logic [IRQ_COUNT-1:0] irq_enable,
  input  wire logic [IRQ_COUNT-1:0] irq_clear,
  output logic [IRQ_COUNT-1:0]      irq_status,
  output logic                      irq_out
);

  // Pin synchroniser and edge history
  pins_type      sync1_reg, sync2_reg, prev_reg;
  pins_type      pins_now;
  // Two-wire engine
  i2c_state_type i2c_state_reg, i2c_state_next;
  logic [3:0]    i2c_cnt_reg, i2c_cnt_next;
  logic [7:0]    i2c_shift_reg, i2c_shift_next;
  logic          i2c_first_reg, i2c_first_next;
  logic          i2c_ack_reg, i2c_ack_next;
  logic          sda_drive_reg, sda_drive_next;
  logic          scl_hold_reg, scl_hold_next;
  logic          busy_reg, busy_next;
  // Four-wire engine
  logic [2:0]    spi_cnt_reg, spi_cnt_next;
  logic [7:0]    spi_rx_reg, spi_rx_next;
  logic [7:0]    spi_tx_reg, spi_tx_next;
  logic          spi_first_reg, spi_first_next;
  logic          spi_read_reg, spi_read_next;
  logic          spi_load_reg, spi_load_next;
  // Shared register access
  logic [7:0]    index_reg, index_next;
  reg_write_type wr_reg, wr_next;
  // Interrupt flags
  logic [IRQ_COUNT-1:0] status_reg, status_next;
  logic          irq_reg, irq_next;
  // Edge events
  logic          scl_rise, scl_fall, start_seen, stop_seen;
  logic          spc_rise, spc_fall, spi_sel, i2c_allowed;
  logic [7:0]    rx_byte;

  // Pins pass two flip-flops before use; third stage finds edges
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sync1_reg <= '{scl: 1'b1, sda: 1'b1, cs_n: 1'b1, sa0: 1'b0};
      sync2_reg <= '{scl: 1'b1, sda: 1'b1, cs_n: 1'b1, sa0: 1'b0};
      prev_reg  <= '{scl: 1'b1, sda: 1'b1, cs_n: 1'b1, sa0: 1'b0};
    end else begin
      sync1_reg <= '{scl: scl_in, sda: sda_in, cs_n: select_n, sa0: addr_lsb_select};
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Edge and condition detection
  always_comb begin
    pins_now    = sync2_reg;
    scl_rise    = pins_now.scl & ~prev_reg.scl;
    scl_fall    = ~pins_now.scl & prev_reg.scl;
    start_seen  = prev_reg.sda & ~pins_now.sda & pins_now.scl & prev_reg.scl;
    stop_seen   = ~prev_reg.sda & pins_now.sda & pins_now.scl & prev_reg.scl;
    spi_sel     = ~pins_now.cs_n;
    spc_rise    = spi_sel & scl_rise;
    spc_fall    = spi_sel & scl_fall;
    i2c_allowed = ~twowire_port_disable & ~spi_sel;
    rx_byte     = {i2c_shift_reg[6:0], pins_now.sda};
  end

  // Next state of both serial engines and the register index
  always_comb begin
    i2c_state_next = i2c_state_reg;
    i2c_cnt_next   = i2c_cnt_reg;
    i2c_shift_next = i2c_shift_reg;
    i2c_first_next = i2c_first_reg;
    i2c_ack_next   = i2c_ack_reg;
    sda_drive_next = sda_drive_reg;
    scl_hold_next  = scl_hold_reg;
    busy_next      = busy_reg;
    spi_cnt_next   = spi_cnt_reg;
    spi_rx_next    = spi_rx_reg;
    spi_tx_next    = spi_tx_reg;
    spi_first_next = spi_first_reg;
    spi_read_next  = spi_read_reg;
    spi_load_next  = spi_load_reg;
    index_next     = index_reg;
    wr_next        = '{valid: 1'b0, index: wr_reg.index, data: wr_reg.data};

    // Two-wire engine
    if (!i2c_allowed) begin
      i2c_state_next = I_IDLE;
      sda_drive_next = 1'b0;
      scl_hold_next  = 1'b0;
      busy_next      = 1'b0;
    end else if (stop_seen) begin
      i2c_state_next = I_IDLE;
      sda_drive_next = 1'b0;
      scl_hold_next  = 1'b0;
      busy_next      = 1'b0;
    end else if (start_seen) begin
      i2c_state_next = I_ADDR;
      i2c_cnt_next   = CNT_ZERO;
      sda_drive_next = 1'b0;
      scl_hold_next  = 1'b0;
      busy_next      = 1'b1;
    end else begin
      case (i2c_state_reg)
        I_IDLE: begin
          sda_drive_next = 1'b0;
        end
        I_ADDR, I_RX: begin
          if (scl_rise) begin
            i2c_shift_next = rx_byte;
            i2c_cnt_next   = i2c_cnt_reg + CNT_ONE;
          end else if (scl_fall && i2c_cnt_reg == BYTE_BITS) begin
            if (i2c_state_reg == I_ADDR) begin
              if (i2c_shift_reg[7:1] == {DEV_ADDR_HI, pins_now.sa0}) begin
                sda_drive_next = 1'b1;
                i2c_ack_next   = i2c_shift_reg[0];
                i2c_state_next = I_ADDR_ACK;
              end else begin
                i2c_state_next = I_IDLE;
              end
            end else begin
              sda_drive_next = 1'b1;
              i2c_state_next = I_RX_ACK;
              if (i2c_first_reg) begin
                index_next = i2c_shift_reg;
              end else begin
                wr_next = '{valid: 1'b1, index: index_reg, data: i2c_shift_reg};
              end
            end
          end
        end
        I_ADDR_ACK: begin
          if (scl_fall) begin
            sda_drive_next = 1'b0;
            i2c_cnt_next   = CNT_ZERO;
            if (i2c_ack_reg) begin
              i2c_state_next = I_STRETCH;
              scl_hold_next  = 1'b1;
            end else begin
              i2c_state_next = I_RX;
              i2c_first_next = 1'b1;
            end
          end
        end
        I_RX_ACK: begin
          if (scl_fall) begin
            sda_drive_next = 1'b0;
            i2c_cnt_next   = CNT_ZERO;
            i2c_state_next = I_RX;
            i2c_first_next = 1'b0;
            if (!i2c_first_reg) begin
              index_next = index_reg + INDEX_STEP;
            end
          end
        end
        I_STRETCH: begin
          if (read_ready) begin
            i2c_shift_next = read_data;
            sda_drive_next = ~read_data[7]; // Data settles before the clock is let go
            i2c_cnt_next   = CNT_ZERO;
            i2c_state_next = I_TX;
          end
        end
        I_TX: begin
          scl_hold_next = 1'b0;
          if (scl_fall) begin
            if (i2c_cnt_reg == TX_LAST) begin
              sda_drive_next = 1'b0;
              i2c_state_next = I_TX_ACK;
            end else begin
              i2c_shift_next = {i2c_shift_reg[6:0], 1'b0};
              sda_drive_next = ~i2c_shift_reg[6];
              i2c_cnt_next   = i2c_cnt_reg + CNT_ONE;
            end
          end
        end
        I_TX_ACK: begin
          if (scl_rise) begin
            i2c_ack_next = ~pins_now.sda;
          end else if (scl_fall) begin
            index_next = index_reg + INDEX_STEP;
            if (i2c_ack_reg) begin
              i2c_state_next = I_STRETCH;
              scl_hold_next  = 1'b1;
            end else begin
              i2c_state_next = I_IDLE;
            end
          end
        end
        default: begin
          i2c_state_next = I_IDLE;
        end
      endcase
    end

    // Four-wire engine, reset by select high
    if (!spi_sel) begin
      spi_cnt_next   = SPI_LAST;
      spi_first_next = 1'b1;
      spi_load_next  = 1'b0;
      spi_tx_next    = BYTE_RESET;
    end else if (spc_rise) begin
      spi_rx_next  = {spi_rx_reg[6:0], pins_now.sda};
      spi_cnt_next = spi_cnt_reg - SPI_ONE;
      if (spi_cnt_reg == SPI_ZERO) begin
        if (spi_first_reg) begin
          spi_read_next  = spi_rx_reg[6];
          index_next     = {1'b0, spi_rx_reg[5:0], pins_now.sda};
          spi_first_next = 1'b0;
          spi_load_next  = spi_rx_reg[6];
        end else if (spi_read_reg) begin
          spi_load_next = 1'b1;
        end else begin
          wr_next    = '{valid: 1'b1, index: index_reg, data: {spi_rx_reg[6:0], pins_now.sda}};
          index_next = index_reg + INDEX_STEP;
        end
      end
    end else if (spc_fall) begin
      if (spi_load_reg) begin
        spi_tx_next   = read_data;
        spi_load_next = 1'b0;
        index_next    = index_reg + INDEX_STEP;
      end else begin
        spi_tx_next = {spi_tx_reg[6:0], 1'b0};
      end
    end
  end

  // Interrupt flags: set wins over clear
  always_comb begin
    status_next = (status_reg & ~irq_clear) | irq_event;
    irq_next    = |(status_reg & irq_enable);
  end

  // Register all engine and flag state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      i2c_state_reg <= I_IDLE;
      i2c_cnt_reg   <= CNT_ZERO;
      i2c_shift_reg <= BYTE_RESET;
      i2c_first_reg <= 1'b0;
      i2c_ack_reg   <= 1'b0;
      sda_drive_reg <= 1'b0;
      scl_hold_reg  <= 1'b0;
      busy_reg      <= 1'b0;
      spi_cnt_reg   <= SPI_LAST;
      spi_rx_reg    <= BYTE_RESET;
      spi_tx_reg    <= BYTE_RESET;
      spi_first_reg <= 1'b1;
      spi_read_reg  <= 1'b0;
      spi_load_reg  <= 1'b0;
      index_reg     <= INDEX_RESET;
      wr_reg        <= '{valid: 1'b0, index: INDEX_RESET, data: BYTE_RESET};
      status_reg    <= IRQ_NONE;
      irq_reg       <= 1'b0;
    end else begin
      i2c_state_reg <= i2c_state_next;
      i2c_cnt_reg   <= i2c_cnt_next;
      i2c_shift_reg <= i2c_shift_next;
      i2c_first_reg <= i2c_first_next;
      i2c_ack_reg   <= i2c_ack_next;
      sda_drive_reg <= sda_drive_next;
      scl_hold_reg  <= scl_hold_next;
      busy_reg      <= busy_next;
      spi_cnt_reg   <= spi_cnt_next;
      spi_rx_reg    <= spi_rx_next;
      spi_tx_reg    <= spi_tx_next;
      spi_first_reg <= spi_first_next;
      spi_read_reg  <= spi_read_next;
      spi_load_reg  <= spi_load_next;
      index_reg     <= index_next;
      wr_reg        <= wr_next;
      status_reg    <= status_next;
      irq_reg       <= irq_next;
    end
  end

  // Pin drivers: open-drain lines only ever pull low
  assign sda_out              = 1'b0;
  assign sda_oe_n             = ~sda_drive_reg;
  assign scl_out              = 1'b0;
  assign scl_oe_n             = ~scl_hold_reg;
  assign serial_data_out      = spi_tx_reg[7];
  assign serial_data_out_oe_n = pins_now.cs_n;
  assign reg_write            = wr_reg;
  assign read_index           = index_reg;
  assign bus_busy             = busy_reg;
  assign irq_status           = status_reg;
  assign irq_out              = irq_reg;

endmodule

/* rtl/serial_port_pkg.sv */
// Constants, states and carriers for the sensor serial slave port
package serial_port_pkg;
  // Documented link rates, kept for reference by users of the block
  localparam int unsigned CLK_KHZ       = 250000;
  localparam int unsigned TWOWIRE_KHZ   = 400;
  localparam int unsigned FOURWIRE_KHZ  = 8000;
  localparam int unsigned SPC_HALF_CYC  = CLK_KHZ / (2 * FOURWIRE_KHZ);
  // Two-wire address: fixed upper six bits, lsb from the select pin
  localparam logic [5:0] DEV_ADDR_HI    = 6'h34;
  // Bit counts
  localparam logic [3:0] BYTE_BITS      = 4'h8;
  localparam logic [3:0] TX_LAST        = 4'h7;
  localparam logic [2:0] SPI_LAST       = 3'h7;
  localparam logic [3:0] CNT_ZERO       = 4'h0;
  localparam logic [3:0] CNT_ONE        = 4'h1;
  localparam logic [2:0] SPI_ONE        = 3'h1;
  localparam logic [2:0] SPI_ZERO       = 3'h0;
  localparam logic [7:0] INDEX_STEP     = 8'h01;
  localparam logic [7:0] INDEX_RESET    = 8'h00;
  localparam logic [7:0] BYTE_RESET     = 8'h00;
  // Interrupt sources
  localparam int unsigned IRQ_COUNT     = 3;
  localparam int unsigned IRQ_MOTION    = 0;
  localparam int unsigned IRQ_OVERFLOW  = 1;
  localparam int unsigned IRQ_DATA_RDY  = 2;
  localparam logic [2:0] IRQ_NONE       = 3'h0;

  typedef enum logic [2:0] {
    I_IDLE     = 3'h0,
    I_ADDR     = 3'h1,
    I_ADDR_ACK = 3'h2,
    I_RX       = 3'h3,
    I_RX_ACK   = 3'h4,
    I_STRETCH  = 3'h5,
    I_TX       = 3'h6,
    I_TX_ACK   = 3'h7
  } i2c_state_type;

  // Pins sampled from outside the clock domain
  typedef struct packed {
    logic scl;
    logic sda;
    logic cs_n;
    logic sa0;
  } pins_type;

  // Register write towards the register file
  typedef struct packed {
    logic       valid;
    logic [7:0] index;
    logic [7:0] data;
  } reg_write_type;
endpackage

/* tb/host_master_model.sv */
// Host processor model: two-wire and four-wire bus master
`timescale 1ns/1ps
module host_master_model (
  input  wire logic clock,
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  input  wire logic serial_data_out,
  input  wire logic serial_data_out_oe_n,
  output logic      scl_in,
  output logic      sda_in,
  output logic      select_n
);
  logic m_scl = 1'h1;
  logic m_sda = 1'h1;
  logic miso_seen;

  // Released data out shows the inverse of what the device last drove
  assign miso_seen = serial_data_out_oe_n ? ~serial_data_out : serial_data_out;

  // Open-drain wires with pull-ups
  assign scl_in = m_scl & scl_oe_n;
  assign sda_in = m_sda & sda_oe_n;

  initial begin
    select_n = 1'h1;
  end

  // Half of one 64 ns link clock period
  task automatic half();
    repeat (8) @(negedge clock);
  endtask

  // One bit; waits out clock stretching under a bound
  task automatic bit_io(input logic b, output logic r);
    int n;
    m_sda = b;
    half();
    m_scl = 1'h1;
    n = 0;
    while (scl_in !== 1'h1 && n < 400) begin
      @(negedge clock);
      n++;
    end
    if (n == 400) tb.stall_fail();
    half();
    r = sda_in;
    m_scl = 1'h0;
    @(negedge clock);
  endtask

  task automatic start();
    m_sda = 1'h1;
    half();
    m_scl = 1'h1;
    half();
    m_sda = 1'h0;
    half();
    m_scl = 1'h0;
  endtask

  task automatic stop();
    m_sda = 1'h0;
    half();
    m_scl = 1'h1;
    half();
    m_sda = 1'h1;
    half();
  endtask

  // Byte out, then ninth clock with SDA released for the acknowledge
  task automatic byte_wr(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'h1, r);
    ack = ~r;
  endtask

  // Byte in, then acknowledge or not-acknowledge on the ninth clock
  task automatic byte_rd(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, d[i]);
    bit_io(last, r);
  endtask

  // Select edge with the link clock standing high
  task automatic sel(input logic v);
    half();
    select_n = v;
    half();
  endtask

  // Data moves on the falling edge, sampled on the rising edge
  task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      m_scl = 1'h0;
      m_sda = tx[i];
      half();
      rx[i] = miso_seen;
      m_scl = 1'h1;
      half();
    end
  endtask
endmodule

/* tb/serial_port_asserts.sv */
// Concurrent checks on the serial slave port pins
`timescale 1ns/1ps
module serial_port_asserts
  import serial_port_pkg::*;
(
  input wire logic                 clock,
  input wire logic                 rst_n,
  input wire logic                 scl_in,
  input wire logic                 scl_oe_n,
  input wire logic                 sda_in,
  input wire logic                 sda_oe_n,
  input wire logic                 select_n,
  input wire logic                 serial_data_out_oe_n,
  input wire reg_write_type        reg_write,
  input wire logic [7:0]           read_index,
  input wire logic                 read_ready,
  input wire logic                 bus_busy,
  input wire logic [IRQ_COUNT-1:0] irq_event,
  input wire logic [IRQ_COUNT-1:0] irq_enable,
  input wire logic [IRQ_COUNT-1:0] irq_clear,
  input wire logic [IRQ_COUNT-1:0] irq_status,
  input wire logic                 irq_out
);
  logic [7:0] wr_index_reg;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  // Bus conditions seen on the raw pins
  sequence s_start;
    $fell(sda_in) && scl_in && select_n;
  endsequence
  sequence s_stop;
    $rose(sda_in) && scl_in && select_n;
  endsequence

  // Remembers the index of the latest register write
  always_ff @(posedge clock) begin
    if (reg_write.valid) begin
      wr_index_reg <= reg_write.index;
    end
  end

  a_sdo_released: assert property (select_n[*4] |-> serial_data_out_oe_n)
    else $error("data out driven while deselected");
  a_sdo_driven: assert property ((!select_n)[*4] |-> !serial_data_out_oe_n)
    else $error("data out not driven while selected");
  a_busy_start: assert property (s_start |-> ##[1:8] bus_busy)
    else $error("start did not make the bus busy");
  a_busy_stop: assert property (s_stop |-> ##[1:8] !bus_busy)
    else $error("stop did not free the bus");
  a_lines_idle: assert property ((!bus_busy)[*3] |-> sda_oe_n && scl_oe_n)
    else $error("line pulled low outside a transaction");
  a_index_step: assert property (reg_write.valid |=> ##[0:40] (read_index == wr_index_reg + INDEX_STEP))
    else $error("index did not advance after a write");
  a_stretch_end: assert property (!scl_oe_n && read_ready |-> ##[1:3] scl_oe_n)
    else $error("clock held low with data ready");
  a_irq_output: assert property (irq_out == |($past(irq_status) & $past(irq_enable)))
    else $error("interrupt output does not follow enabled flags");
  a_flag_set: assert property ((irq_event != IRQ_NONE) |=> (irq_status & $past(irq_event)) == $past(irq_event))
    else $error("event did not set its flag");
  a_flag_hold: assert property ((irq_event == IRQ_NONE) && (irq_clear == IRQ_NONE) |=> $stable(irq_status))
    else $error("flag changed with no event or clear");
endmodule

/* tb/tb.sv */
// Self-checking bench for the sensor serial slave port
`timescale 1ns/1ps
module tb;
  import serial_port_pkg::*;
  logic                 clock, rst_n, scl_in, scl_out, scl_oe_n, sda_in, sda_out, sda_oe_n;
  logic                 select_n, addr_lsb_select, serial_data_out, serial_data_out_oe_n;
  logic                 twowire_port_disable, read_ready, bus_busy, irq_out;
  reg_write_type        reg_write;
  logic [7:0]           read_index, read_data;
  logic [IRQ_COUNT-1:0] irq_event, irq_enable, irq_clear, irq_status;
  int                   err_count = 0;
  int                   checked = 0;
  logic [15:0]          wr_q[$];

  sensor_serial_slave_port uut (
    .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .select_n(select_n),
    .addr_lsb_select(addr_lsb_select), .serial_data_out(serial_data_out),
    .serial_data_out_oe_n(serial_data_out_oe_n), .twowire_port_disable(twowire_port_disable),
    .reg_write(reg_write), .read_index(read_index), .read_data(read_data), .read_ready(read_ready),
    .bus_busy(bus_busy), .irq_event(irq_event), .irq_enable(irq_enable), .irq_clear(irq_clear),
    .irq_status(irq_status), .irq_out(irq_out));

  host_master_model host (
    .clock(clock), .scl_oe_n(scl_oe_n), .sda_oe_n(sda_oe_n), .serial_data_out(serial_data_out),
    .serial_data_out_oe_n(serial_data_out_oe_n), .scl_in(scl_in), .sda_in(sda_in), .select_n(select_n));

  // Register file stand-in and write collector
  assign read_data = read_index ^ 8'h5A;
  always @(posedge clock) begin
    if (reg_write.valid === 1'h1) wr_q.push_back({reg_write.index, reg_write.data});
  end

  initial begin
    clock = 1'h0;
    forever #2 clock = ~clock;
  end

  task automatic cmp8(input logic [7:0] a, input logic [7:0] e);
    checked++;
    if (a !== e) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, a, e);
    end
  endtask
  task automatic cmp1(input logic a, input logic e);
    cmp8({7'h00, a}, {7'h00, e});
  endtask
  task automatic chk_wr(input logic [7:0] idx, input logic [7:0] dat);
    logic [15:0] w;
    w = ~{idx, dat};
    if (wr_q.size() != 0) w = wr_q.pop_front();
    cmp8(w[15:8], idx);
    cmp8(w[7:0], dat);
  endtask
  task automatic conclude();
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic stall_fail();
    err_count++;
    conclude();
  endtask

  task automatic t_i2c_write();
    logic a;
    addr_lsb_select = 1'h0;
    host.start();
    host.byte_wr(8'hD0, a);
    cmp1(a, 1'h1);
    host.byte_wr(8'h10, a);
    cmp1(a, 1'h1);
    host.byte_wr(8'hA5, a);
    cmp1(a, 1'h1);
    host.byte_wr(8'h3C, a);
    cmp1(a, 1'h1);
    host.stop();
    chk_wr(8'h10, 8'hA5);
    chk_wr(8'h11, 8'h3C);
    $display("test two-wire write done");
  endtask

  task automatic t_i2c_addr();
    logic a;
    addr_lsb_select = 1'h1;
    host.start();
    host.byte_wr(8'hD0, a);
    cmp1(a, 1'h0);
    host.stop();
    host.start();
    host.byte_wr(8'hD2, a);
    cmp1(a, 1'h1);
    host.byte_wr(8'h40, a);
    host.stop();
    cmp8(8'(wr_q.size()), 8'h00);
    $display("test two-wire address done");
  endtask

  task automatic t_i2c_read();
    logic       a;
    logic [7:0] d;
    addr_lsb_select = 1'h0;
    read_ready = 1'h0;
    host.start();
    host.byte_wr(8'hD0, a);
    host.byte_wr(8'h20, a);
    host.start();
    cmp1(bus_busy, 1'h1);
    host.byte_wr(8'hD1, a);
    cmp1(a, 1'h1);
    fork
      host.byte_rd(1'h0, d);
      begin
        repeat (40) @(negedge clock);
        cmp1(scl_oe_n, 1'h0);
        read_ready = 1'h1;
      end
    join
    cmp8(d, 8'h20 ^ 8'h5A);
    host.byte_rd(1'h1, d);
    cmp8(d, 8'h21 ^ 8'h5A);
    host.stop();
    cmp1(bus_busy, 1'h0);
    $display("test two-wire read done");
  endtask

  task automatic t_spi();
    logic [7:0] r;
    twowire_port_disable = 1'h1;
    host.sel(1'h0);
    host.spi_byte(8'h05, r);
    host.spi_byte(8'h11, r);
    host.spi_byte(8'h22, r);
    host.sel(1'h1);
    chk_wr(8'h05, 8'h11);
    chk_wr(8'h06, 8'h22);
    cmp1(serial_data_out_oe_n, 1'h1);
    host.sel(1'h0);
    host.spi_byte(8'hB0, r);
    host.spi_byte(8'h00, r);
    cmp8(r, 8'h30 ^ 8'h5A);
    host.spi_byte(8'h00, r);
    cmp8(r, 8'h31 ^ 8'h5A);
    host.sel(1'h1);
    twowire_port_disable = 1'h0;
    $display("test four-wire done");
  endtask

  task automatic irq_step(input logic [2:0] ev, input logic [2:0] clr, input logic [2:0] st, input logic o);
    irq_event = ev;
    irq_clear = clr;
    @(negedge clock);
    irq_event = IRQ_NONE;
    irq_clear = IRQ_NONE;
    @(negedge clock);
    cmp8({5'h00, irq_status}, {5'h00, st});
    cmp1(irq_out, o);
  endtask

  task automatic t_irq();
    irq_enable = 3'h5;
    irq_step(3'h2, 3'h0, 3'h2, 1'h0);
    irq_step(3'h1, 3'h0, 3'h3, 1'h1);
    irq_step(3'h0, 3'h1, 3'h2, 1'h0);
    irq_step(3'h4, 3'h4, 3'h6, 1'h1);
    irq_step(3'h0, 3'h6, 3'h0, 1'h0);
    $display("test interrupts done");
  endtask

  // Reset, reset values, then each scenario in turn
  initial begin
    rst_n = 1'h0;
    addr_lsb_select = 1'h0;
    twowire_port_disable = 1'h0;
    read_ready = 1'h1;
    irq_event = IRQ_NONE;
    irq_enable = IRQ_NONE;
    irq_clear = IRQ_NONE;
    repeat (6) @(negedge clock);
    rst_n = 1'h1;
    repeat (3) @(negedge clock);
    cmp8(read_index, INDEX_RESET);
    cmp1(bus_busy, 1'h0);
    cmp1(scl_out, 1'h0);
    cmp1(sda_out, 1'h0);
    t_i2c_write();
    t_i2c_addr();
    t_i2c_read();
    t_spi();
    t_irq();
    conclude();
  end
endmodule

bind sensor_serial_slave_port serial_port_asserts chk (
  .clock(clock), .rst_n(rst_n), .scl_in(scl_in), .scl_oe_n(scl_oe_n), .sda_in(sda_in), .sda_oe_n(sda_oe_n),
  .select_n(select_n), .serial_data_out_oe_n(serial_data_out_oe_n), .reg_write(reg_write),
  .read_index(read_index), .read_ready(read_ready), .bus_busy(bus_busy), .irq_event(irq_event),
  .irq_enable(irq_enable), .irq_clear(irq_clear), .irq_status(irq_status), .irq_out(irq_out));
